// ==== vsync_pkg.sv ====
// Package: register map, control fields, reset values and timing constants
package vsync_pkg;

    // ---------------------------------------------------------------
    // Register offsets (byte addresses, one 32-bit word each)
    // ---------------------------------------------------------------
    localparam logic [7:0] DPY_CTL_OFS = 8'h00;
    localparam logic [7:0] HTIMING_OFS = 8'h04;
    localparam logic [7:0] VTIMING_OFS = 8'h08;
    localparam logic [7:0] SYNC_PRESET_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] SHIFT_CTL_OFS = 8'h14;

    // ---------------------------------------------------------------
    // Display control fields
    // ---------------------------------------------------------------
    localparam int SEP_SYNC_BIT = 0;
    localparam int COMBINED_SYNC_PIN_OUT_BIT = 1;
    localparam int HSYNC_OUT_BIT = 2;
    localparam int VSYNC_OUT_BIT = 3;
    localparam int COMBINED_SYNC_PIN_EXT_SRC_BIT = 4;
    localparam int PRESET_EN_BIT = 5;
    localparam int TIMER_EN_BIT = 6;
    localparam logic [6:0] DPY_CTL_RST = 7'h40;

    // ---------------------------------------------------------------
    // Timing register reset values (counts in video clock cycles / lines / shift clock edges)
    // ---------------------------------------------------------------
    localparam logic [11:0] HTOTAL_RST = 12'h063;
    localparam logic [11:0] HSYNC_END_RST = 12'h007;
    localparam logic [11:0] HBLANK_END_RST = 12'h00f;
    localparam logic [11:0] HBLANK_START_RST = 12'h05f;
    localparam logic [11:0] VTOTAL_RST = 12'h01f;
    localparam logic [11:0] VSYNC_END_RST = 12'h001;
    localparam logic [11:0] VBLANK_END_RST = 12'h003;
    localparam logic [11:0] VBLANK_START_RST = 12'h01d;
    localparam logic [11:0] SHIFT_LEN_RST = 12'h0ff;
    localparam logic [11:0] MIDLINE_POINT_RST = 12'h07f;

    // Composite sync separation: a low pulse longer than this is vertical
    localparam int COMBINED_SYNC_PIN_VPULSE_NS = 400;
    localparam int CLK_PERIOD_NS = 4;
    localparam int COMBINED_SYNC_PIN_VPULSE_CYC = (COMBINED_SYNC_PIN_VPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : vsync_pkg

// ==== sync_2ff.sv ====
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module sync_2ff (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_q <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sync_2ff

// ==== video_sync_ctrl.sv ====
// Video sync and blanking pin control with shift-clock tracking
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

// Functional notes
// - Composite mode: combined blank active in horizontal and vertical retrace.
// - Separate mode: shared blank output is vertical blank only.
// - After reset the shared blank pin acts as combined blank.
// - Composite mode: control bit picks combined sync pin direction.
// - Combined sync input: separate horizontal and vertical timing from it.
// - Combined sync output: active-low, from external syncs or internal timers.
// - Separate mode: combined sync pin is output-only horizontal blank.
// - After reset the combined sync pin is an input.
// - Control bit selects horizontal sync pin direction.
// - Horizontal sync output is active-low from internal timers.
// - Horizontal sync input resyncs timers at programmable cycle.
// - After reset horizontal sync pin is an input.
// - Control bit selects vertical sync pin direction.
// - Vertical sync output is active-low from internal timers.
// - Vertical sync input resyncs timers at programmable line.
// - After reset vertical sync pin is an input.
// - All video timing runs on the video timing clock.
// - Count shift clock edges to schedule transfer and midline reload.
// - External sync may load preset values into the counters.
module video_sync_ctrl #(
    parameter int CNT_W = 12
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic combined_sync_pin_i,
    output logic combined_sync_pin_o,
    output logic combined_sync_pin_oe,
    input wire logic hsync_pin_i,
    output logic hsync_pin_o,
    output logic hsync_pin_oe,
    input wire logic vsync_pin_i,
    output logic vsync_pin_o,
    output logic vsync_pin_oe,
    output logic combined_blank_out_n,
    input wire logic shift_clk,
    output logic xfer_req,
    output logic midline_req
);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [6:0] ctl_q;
    logic [CNT_W-1:0] htotal_q, hsync_end_q, hblank_end_q, hblank_start_q;
    logic [CNT_W-1:0] vtotal_q, vsync_end_q, vblank_end_q, vblank_start_q;
    logic [CNT_W-1:0] hpreset_q, vpreset_q;
    logic [CNT_W-1:0] shift_len_q, midline_pt_q;
    logic [CNT_W-1:0] hcnt_q, vcnt_q, shift_cnt_q;
    logic hsync_int, vsync_int, hblank_int, vblank_int;

    // Control decode
    logic sep_mode, combined_sync_pin_out, hsync_out, vsync_out, combined_sync_pin_ext, preset_en, timer_en;
    assign sep_mode = ctl_q[vsync_pkg::SEP_SYNC_BIT];
    assign combined_sync_pin_out = ctl_q[vsync_pkg::COMBINED_SYNC_PIN_OUT_BIT];
    assign hsync_out = ctl_q[vsync_pkg::HSYNC_OUT_BIT];
    assign vsync_out = ctl_q[vsync_pkg::VSYNC_OUT_BIT];
    assign combined_sync_pin_ext = ctl_q[vsync_pkg::COMBINED_SYNC_PIN_EXT_SRC_BIT];
    assign preset_en = ctl_q[vsync_pkg::PRESET_EN_BIT];
    assign timer_en = ctl_q[vsync_pkg::TIMER_EN_BIT];

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic combined_sync_pin_s, hsync_s, vsync_s, sclk_s;

    sync_2ff u_sync_combined_sync_pin (.clk_sys(clk_sys), .srst(srst), .async_in(combined_sync_pin_i),
        .sync_out(combined_sync_pin_s));
    sync_2ff u_sync_hsync (.clk_sys(clk_sys), .srst(srst), .async_in(hsync_pin_i),
        .sync_out(hsync_s));
    sync_2ff u_sync_vsync (.clk_sys(clk_sys), .srst(srst), .async_in(vsync_pin_i),
        .sync_out(vsync_s));
    sync_2ff u_sync_sclk (.clk_sys(clk_sys), .srst(srst), .async_in(shift_clk),
        .sync_out(sclk_s));

    // ---------------------------------------------------------------
    // Edge history of synchronised inputs
    // ---------------------------------------------------------------
    logic combined_sync_pin_d_q, hsync_d_q, vsync_d_q, sclk_d_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            combined_sync_pin_d_q <= 1'b1;
            hsync_d_q <= 1'b1;
            vsync_d_q <= 1'b1;
            sclk_d_q <= 1'b1; // Matches the synchroniser reset, so no false edge
        end else begin
            combined_sync_pin_d_q <= combined_sync_pin_s;
            hsync_d_q <= hsync_s;
            vsync_d_q <= vsync_s;
            sclk_d_q <= sclk_s;
        end
    end

    // ---------------------------------------------------------------
    // Composite sync separator
    // ---------------------------------------------------------------
    // A low pulse that outlasts the threshold is taken as vertical sync;
    // every falling edge still marks a line start. Serration is ignored.
    logic [15:0] clow_cnt_q;
    logic csep_vs_q;
    logic combined_sync_pin_sep_active;
    assign combined_sync_pin_sep_active = !sep_mode && !combined_sync_pin_out;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clow_cnt_q <= '0;
            csep_vs_q <= 1'b0;
        end else if (!combined_sync_pin_s) begin
            if (clow_cnt_q != 16'hffff)
                clow_cnt_q <= clow_cnt_q + 16'h0001;
            csep_vs_q <= combined_sync_pin_sep_active &&
                (clow_cnt_q == 16'(vsync_pkg::COMBINED_SYNC_PIN_VPULSE_CYC));
        end else begin
            clow_cnt_q <= '0;
            csep_vs_q <= 1'b0;
        end
    end

    // External sync events (falling edges of the synchronised inputs, or a long combined sync low)
    logic ext_h_evt, ext_v_evt;
    assign ext_h_evt = (!hsync_out && hsync_d_q && !hsync_s) ||
        (combined_sync_pin_sep_active && combined_sync_pin_d_q && !combined_sync_pin_s);
    assign ext_v_evt = (!vsync_out && vsync_d_q && !vsync_s) || csep_vs_q;

    // Pending vertical event waits for the next line start so that the
    // programmable line preset lands on a line boundary.
    logic vpend_q;

    always_ff @(posedge clk_sys) begin
        if (srst)
            vpend_q <= 1'b0;
        else if (ext_v_evt)
            vpend_q <= 1'b1;
        else if (ext_h_evt)
            vpend_q <= 1'b0;
    end

    // ---------------------------------------------------------------
    // Video timers (run on the video timing clock)
    // ---------------------------------------------------------------
    logic h_wrap, v_wrap;
    assign h_wrap = (hcnt_q == htotal_q);
    assign v_wrap = (vcnt_q == vtotal_q);

    // Horizontal counter; external sync loads the programmed cycle
    always_ff @(posedge clk_sys) begin
        if (srst)
            hcnt_q <= '0;
        else if (!timer_en)
            hcnt_q <= '0;
        else if (ext_h_evt && preset_en)
            hcnt_q <= hpreset_q;
        else if (h_wrap)
            hcnt_q <= '0;
        else
            hcnt_q <= hcnt_q + 1'b1;
    end

    // Vertical counter; external vertical sync loads the programmed line
    always_ff @(posedge clk_sys) begin
        if (srst)
            vcnt_q <= '0;
        else if (!timer_en)
            vcnt_q <= '0;
        else if (ext_h_evt && preset_en && (vpend_q || ext_v_evt))
            vcnt_q <= vpreset_q;
        else if (h_wrap)
            vcnt_q <= v_wrap ? '0 : vcnt_q + 1'b1;
    end

    // Sync and blank intervals from the counters, active high internally
    assign hsync_int = timer_en && (hcnt_q < hsync_end_q);
    assign vsync_int = timer_en && (vcnt_q < vsync_end_q);
    assign hblank_int = timer_en && ((hcnt_q < hblank_end_q) || (hcnt_q >= hblank_start_q));
    assign vblank_int = timer_en && ((vcnt_q < vblank_end_q) || (vcnt_q >= vblank_start_q));

    // ---------------------------------------------------------------
    // Pin drivers (all outputs registered)
    // ---------------------------------------------------------------
    // Horizontal and vertical sync pins
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hsync_pin_oe <= 1'b0;
            hsync_pin_o <= 1'b1;
            vsync_pin_oe <= 1'b0;
            vsync_pin_o <= 1'b1;
        end else begin
            hsync_pin_oe <= hsync_out;
            hsync_pin_o <= !hsync_int;
            vsync_pin_oe <= vsync_out;
            vsync_pin_o <= !vsync_int;
        end
    end

    // Shared sync pin: composite sync in or out, or horizontal blank
    // Externally sourced composite sync uses the synchronised pins, so it
    // trails them by the synchroniser latency.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            combined_sync_pin_oe <= 1'b0;
            combined_sync_pin_o <= 1'b1;
        end else if (sep_mode) begin
            combined_sync_pin_oe <= 1'b1;
            combined_sync_pin_o <= !hblank_int;
        end else begin
            combined_sync_pin_oe <= combined_sync_pin_out;
            if (combined_sync_pin_ext)
                combined_sync_pin_o <= hsync_s & vsync_s;
            else
                combined_sync_pin_o <= !(hsync_int || vsync_int);
        end
    end

    // Shared blank pin: composite blank or vertical blank
    always_ff @(posedge clk_sys) begin
        if (srst)
            combined_blank_out_n <= 1'b1;
        else if (sep_mode)
            combined_blank_out_n <= !vblank_int;
        else
            combined_blank_out_n <= !(hblank_int || vblank_int);
    end

    // ---------------------------------------------------------------
    // Shift clock tracking
    // ---------------------------------------------------------------
    // Rising edges of the shift clock advance the serial register position;
    // it must run slower than half the system clock to be seen reliably.
    logic sclk_rise;
    assign sclk_rise = sclk_s && !sclk_d_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            shift_cnt_q <= '0;
            xfer_req <= 1'b0;
            midline_req <= 1'b0;
        end else begin
            xfer_req <= 1'b0;
            midline_req <= 1'b0;
            if (timer_en && h_wrap && v_wrap) begin
                shift_cnt_q <= '0;
                xfer_req <= 1'b1;
            end else if (sclk_rise) begin
                if (shift_cnt_q == shift_len_q) begin
                    shift_cnt_q <= '0;
                    xfer_req <= 1'b1;
                end else begin
                    shift_cnt_q <= shift_cnt_q + 1'b1;
                end
                midline_req <= (shift_cnt_q == midline_pt_q);
            end
        end
    end

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctl_q <= vsync_pkg::DPY_CTL_RST;
            htotal_q <= CNT_W'(vsync_pkg::HTOTAL_RST);
            hsync_end_q <= CNT_W'(vsync_pkg::HSYNC_END_RST);
            hblank_end_q <= CNT_W'(vsync_pkg::HBLANK_END_RST);
            hblank_start_q <= CNT_W'(vsync_pkg::HBLANK_START_RST);
            vtotal_q <= CNT_W'(vsync_pkg::VTOTAL_RST);
            vsync_end_q <= CNT_W'(vsync_pkg::VSYNC_END_RST);
            hpreset_q <= '0;
            vpreset_q <= '0;
            shift_len_q <= CNT_W'(vsync_pkg::SHIFT_LEN_RST);
            midline_pt_q <= CNT_W'(vsync_pkg::MIDLINE_POINT_RST);
        end else if (reg_wr) begin
            case (reg_addr)
                vsync_pkg::DPY_CTL_OFS: ctl_q <= reg_wdata[6:0];
                vsync_pkg::HTIMING_OFS: begin
                    htotal_q <= reg_wdata[CNT_W-1:0];
                    hsync_end_q <= reg_wdata[16+CNT_W-1:16];
                end
                vsync_pkg::VTIMING_OFS: begin
                    vtotal_q <= reg_wdata[CNT_W-1:0];
                    vsync_end_q <= reg_wdata[16+CNT_W-1:16];
                end
                vsync_pkg::SYNC_PRESET_OFS: begin
                    hpreset_q <= reg_wdata[CNT_W-1:0];
                    vpreset_q <= reg_wdata[16+CNT_W-1:16];
                end
                vsync_pkg::SHIFT_CTL_OFS: begin
                    shift_len_q <= reg_wdata[CNT_W-1:0];
                    midline_pt_q <= reg_wdata[16+CNT_W-1:16];
                end
                vsync_pkg::STATUS_OFS: begin
                    hblank_end_q <= reg_wdata[CNT_W-1:0];
                    hblank_start_q <= reg_wdata[16+CNT_W-1:16];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                vsync_pkg::DPY_CTL_OFS: reg_rdata <= {25'h0, ctl_q};
                vsync_pkg::HTIMING_OFS:
                    reg_rdata <= {4'h0, hsync_end_q, 4'h0, htotal_q};
                vsync_pkg::VTIMING_OFS:
                    reg_rdata <= {4'h0, vsync_end_q, 4'h0, vtotal_q};
                vsync_pkg::SYNC_PRESET_OFS:
                    reg_rdata <= {4'h0, vpreset_q, 4'h0, hpreset_q};
                vsync_pkg::SHIFT_CTL_OFS:
                    reg_rdata <= {4'h0, midline_pt_q, 4'h0, shift_len_q};
                vsync_pkg::STATUS_OFS:
                    reg_rdata <= {4'h0, vcnt_q, 4'h0, hcnt_q};
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Vertical blank end follows the vertical sync end and blank start the vertical total, at fixed margins
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            vblank_end_q <= CNT_W'(vsync_pkg::VBLANK_END_RST);
            vblank_start_q <= CNT_W'(vsync_pkg::VBLANK_START_RST);
        end else if (reg_wr && reg_addr == vsync_pkg::VTIMING_OFS) begin
            vblank_end_q <= reg_wdata[16+CNT_W-1:16] + CNT_W'(2);
            vblank_start_q <= reg_wdata[CNT_W-1:0] - CNT_W'(2);
        end
    end

endmodule : video_sync_ctrl

// ==== display_side_model.sv ====
// Model of the display circuitry and VRAM serial port beside the sync pins
`timescale 1ns/1ps
module display_side_model (
    input wire logic shift_run,
    input wire logic hs_ext,
    input wire logic vs_ext,
    input wire logic cs_ext,
    input wire logic hsync_pin_o,
    input wire logic hsync_pin_oe,
    input wire logic vsync_pin_o,
    input wire logic vsync_pin_oe,
    input wire logic combined_sync_pin_o,
    input wire logic combined_sync_pin_oe,
    output logic hsync_pin_i,
    output logic vsync_pin_i,
    output logic combined_sync_pin_i,
    output logic shift_clk
);
    // -----------------------------------------------------------------
    // Pin resolution and serial clock
    // -----------------------------------------------------------------
    // The display drives a sync line only while the controller releases it
    assign hsync_pin_i = hsync_pin_oe ? hsync_pin_o : hs_ext;
    assign vsync_pin_i = vsync_pin_oe ? vsync_pin_o : vs_ext;
    assign combined_sync_pin_i = combined_sync_pin_oe ? combined_sync_pin_o : cs_ext;

    // Serial clock with its own phase; stands still while no line is shifted
    initial begin
        shift_clk = 1'b0;
        #13;
        forever begin
            #40;
            shift_clk = shift_run ? ~shift_clk : 1'b0;
        end
    end
endmodule : display_side_model

// ==== video_sync_ctrl_props.sv ====
// Checker of pin directions, reset state and pulse shapes of the sync controller
`timescale 1ns/1ps
module video_sync_ctrl_chk #(
    parameter int CNT_W = 12
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic combined_sync_pin_o,
    input wire logic combined_sync_pin_oe,
    input wire logic hsync_pin_o,
    input wire logic hsync_pin_oe,
    input wire logic vsync_pin_oe,
    input wire logic combined_blank_out_n,
    input wire logic xfer_req,
    input wire logic midline_req
);
    // -----------------------------------------------------------------
    // Mode tracking
    // -----------------------------------------------------------------
    logic ctl_wr;
    logic hs_low;
    logic steady;
    logic sep_q;
    logic [2:0] since_q;
    assign ctl_wr = reg_wr && (reg_addr == vsync_pkg::DPY_CTL_OFS);
    assign hs_low = hsync_pin_oe && !hsync_pin_o;
    assign steady = (since_q == 3'h7);

    // Mode relations are skipped for a few cycles after a control write
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sep_q <= 1'b0;
            since_q <= 3'h0;
        end else if (ctl_wr) begin
            sep_q <= reg_wdata[vsync_pkg::SEP_SYNC_BIT];
            since_q <= 3'h0;
        end else if (!steady) begin
            since_q <= since_q + 3'h1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_dir(en, b, oe);
        (ctl_wr && en) |-> ##2 (oe == $past(reg_wdata[b], 2));
    endproperty

    chk_reset_pins: assert property ($past(srst) |->
        !hsync_pin_oe && !vsync_pin_oe && !combined_sync_pin_oe && combined_blank_out_n)
        else $error("pins not in reset state");
    // Read data must be quiet outside the answer cycle
    chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
    chk_hs_dir: assert property (p_dir(1'b1, vsync_pkg::HSYNC_OUT_BIT, hsync_pin_oe))
        else $error("hsync direction wrong");
    chk_vs_dir: assert property (p_dir(1'b1, vsync_pkg::VSYNC_OUT_BIT, vsync_pin_oe))
        else $error("vsync direction wrong");
    chk_cs_dir: assert property (p_dir(!reg_wdata[0], 1, combined_sync_pin_oe))
        else $error("combined sync direction wrong");
    chk_sep_drive: assert property (ctl_wr && reg_wdata[0] |-> ##[1:3] combined_sync_pin_oe)
        else $error("separate mode pin not driven");
    chk_comp_blank: assert property (!sep_q && steady && hs_low |-> !combined_blank_out_n)
        else $error("no blank during horizontal sync");
    chk_sep_hblank: assert property (sep_q && steady && hs_low |-> !combined_sync_pin_o)
        else $error("no horizontal blank during sync");
    chk_xfer_pulse: assert property (xfer_req |=> !xfer_req)
        else $error("transfer request too long");
    chk_mid_pulse: assert property (midline_req |=> !midline_req)
        else $error("midline request too long");

    cover_sep_hblank: cover property (sep_q && steady && !combined_sync_pin_o);
    cover_xfer: cover property (xfer_req);
    cover_midline: cover property (midline_req);
endmodule : video_sync_ctrl_chk

bind video_sync_ctrl video_sync_ctrl_chk #(.CNT_W(CNT_W)) chk_u (
    .clk_sys(clk_sys),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .combined_sync_pin_o(combined_sync_pin_o),
    .combined_sync_pin_oe(combined_sync_pin_oe),
    .hsync_pin_o(hsync_pin_o),
    .hsync_pin_oe(hsync_pin_oe),
    .vsync_pin_oe(vsync_pin_oe),
    .combined_blank_out_n(combined_blank_out_n),
    .xfer_req(xfer_req),
    .midline_req(midline_req)
);

// ==== tb_top.sv ====
// Testbench for the video sync and blanking pin controller
`timescale 1ns/1ps
`define CHK(a, e) begin \
    checks_done++; \
    if ((a) !== (e)) begin \
        n_errors++; \
        $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (e)); \
    end \
end
module tb_top;
    localparam int LINE = int'(vsync_pkg::HTOTAL_RST) + 1;
    localparam int FRAME = LINE * (int'(vsync_pkg::VTOTAL_RST) + 1);
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic hs_i, hs_o, hs_oe, vs_i, vs_o, vs_oe, cs_i, cs_o, cs_oe, blank_n;
    logic shift_clk, xfer_req, midline_req;
    logic shift_run = 1'b0;
    logic hs_ext = 1'b1;
    logic cs_ext = 1'b1;
    logic [31:0] rd_q;
    logic [11:0] hp;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int n, nx, nm;

    always #2 clk_sys = ~clk_sys;

    video_sync_ctrl dut_u (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .combined_sync_pin_i(cs_i), .combined_sync_pin_o(cs_o), .combined_sync_pin_oe(cs_oe),
        .hsync_pin_i(hs_i), .hsync_pin_o(hs_o), .hsync_pin_oe(hs_oe), .vsync_pin_i(vs_i),
        .vsync_pin_o(vs_o), .vsync_pin_oe(vs_oe), .combined_blank_out_n(blank_n),
        .shift_clk(shift_clk), .xfer_req(xfer_req), .midline_req(midline_req));

    display_side_model model_u (.shift_run(shift_run), .hs_ext(hs_ext), .vs_ext(1'b1),
        .cs_ext(cs_ext), .hsync_pin_o(hs_o), .hsync_pin_oe(hs_oe), .vsync_pin_o(vs_o),
        .vsync_pin_oe(vs_oe), .combined_sync_pin_o(cs_o), .combined_sync_pin_oe(cs_oe),
        .hsync_pin_i(hs_i), .vsync_pin_i(vs_i), .combined_sync_pin_i(cs_i),
        .shift_clk(shift_clk));

    // -----------------------------------------------------------------
    // Bus access and measurement
    // -----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    function automatic logic pick(input int sel);
        case (sel)
            0: return hs_o;
            1: return vs_o;
            2: return cs_o;
            default: return blank_n;
        endcase
    endfunction : pick

    // Waits for a fall, then counts the low phase and, if asked, the high phase
    task automatic span(input int sel, input bit whole, output int len);
        int k;
        k = 0;
        len = 0;
        while (pick(sel) !== 1'b1 && k < 20000) begin @(posedge clk_sys); #1; k++; end
        while (pick(sel) !== 1'b0 && k < 20000) begin @(posedge clk_sys); #1; k++; end
        while (pick(sel) !== 1'b1 && k < 20000) begin @(posedge clk_sys); #1; k++; len++; end
        while (whole && pick(sel) !== 1'b0 && k < 20000) begin
            @(posedge clk_sys);
            #1;
            k++;
            len++;
        end
    endtask : span

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // Cuts a hang short; the whole run needs about 12000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            $display("CHECK FAILED t=%0t run did not finish", $time);
            complete_run();
        end
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        rd(vsync_pkg::DPY_CTL_OFS, rd_q);
        `CHK(rd_q, {25'h0, vsync_pkg::DPY_CTL_RST})
        // Timers start at line 0, cycle 0: inside both blank intervals
        `CHK({hs_oe, vs_oe, cs_oe, blank_n}, 4'h0)
        rd(8'hfc, rd_q);
        `CHK(rd_q, 32'h0)
        $display("test reset done");
        // Composite mode, every sync pin driven from the timers
        wr(vsync_pkg::DPY_CTL_OFS, 32'h0000_004e);
        repeat (4) @(posedge clk_sys);
        `CHK({cs_oe, hs_oe, vs_oe}, 3'h7)
        span(0, 1'b1, n);
        `CHK(n, LINE)
        span(1, 1'b1, n);
        `CHK(n, FRAME)
        span(2, 1'b1, n);
        `CHK(n > 0, 1'b1)
        $display("test composite outputs done");
        // Separate mode: shared blank covers whole lines only
        wr(vsync_pkg::DPY_CTL_OFS, 32'h0000_0045);
        repeat (4) @(posedge clk_sys);
        `CHK(cs_oe, 1'b1)
        span(3, 1'b0, n);
        `CHK((n % LINE == 0) && (n > LINE), 1'b1)
        $display("test separate mode done");
        // External horizontal sync loads the programmed preset
        wr(vsync_pkg::DPY_CTL_OFS, 32'h0000_0060);
        for (int i = 0; i < 2; i++) begin
            hp = 12'h010 + 12'h040 * i[11:0];
            wr(vsync_pkg::SYNC_PRESET_OFS, {20'h0, hp});
            @(posedge clk_sys);
            hs_ext <= 1'b0;
            repeat (6) @(posedge clk_sys);
            rd(vsync_pkg::STATUS_OFS, rd_q);
            hs_ext <= 1'b1;
            `CHK(rd_q[11:0] - hp <= 12'd12, 1'b1)
            repeat (LINE) @(posedge clk_sys);
        end
        // Long combined sync low marks a frame; the next fall loads the line preset
        wr(vsync_pkg::SYNC_PRESET_OFS, 32'h0005_0010);
        cs_ext <= 1'b0;
        repeat (110) @(posedge clk_sys);
        cs_ext <= 1'b1;
        repeat (4) @(posedge clk_sys);
        cs_ext <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(vsync_pkg::STATUS_OFS, rd_q);
        cs_ext <= 1'b1;
        `CHK(rd_q[27:16], 12'h005)
        $display("test external sync done");
        // Serial clock tracking: eight edges a wrap, midline at three
        wr(vsync_pkg::SHIFT_CTL_OFS, 32'h0003_0007);
        shift_run <= 1'b1;
        nx = 0;
        nm = 0;
        repeat (1280) begin
            @(posedge clk_sys);
            #1;
            nx += (xfer_req === 1'b1);
            nm += (midline_req === 1'b1);
        end
        shift_run <= 1'b0;
        `CHK(nx inside {[7:10]}, 1'b1)
        `CHK(nm inside {[7:9]}, 1'b1)
        $display("test shift tracking done");
        complete_run();
    end
endmodule : tb_top
